// ### rtl/status_change_irq_config.v
// Purpose: Status-change interrupt configuration, flags and routing for
//          one 16-bit card socket, behind an Avalon-MM slave.
// Assumes: All card inputs synchronous to core_clk; one clock domain.
// Notes:   Every access takes two cycles: waitrequest low in the second.
// Behaviour
// - Config bits 7-4 pick a legacy IRQ by code; code 0010 picks SYSTEM_MGMT_INTERRUPT.
// - Code 0000 with diagnostic bit 5 set routes to PCI, ignoring bit 4.
// - Code 0000, diagnostic clear: no legacy line; PCI only if bit 4 set.
// - Config bit 3 lets either card-detect change raise an interrupt.
// - Config bit 2 lets a rising ready line raise an interrupt on a memory card.
// - Config bit 1 lets a battery warning raise an interrupt on a memory card.
// - Config bit 0 lets battery dead or status pin raise an interrupt.
// - Disabled source flags read zero; enabled events set their flag.
// - Flags clear by status read or write-one, chosen by global bit 2.
//
// The Avalon-MM interface to the registers was chosen for this implementation.
`timescale 1ns/100ps
`include "csc_defs.vh"

module status_change_irq_config (
    input  wire                       core_clk,
    input  wire                       resetn,
    // Avalon-MM slave
    input  wire [`ADDR_W-1:0]         address,
    input  wire                       read,
    input  wire                       write,
    input  wire [31:0]                writedata,
    input  wire [3:0]                 byteenable,
    output reg  [31:0]                readdata,
    output reg                        waitrequest,
    // Card side
    input  wire                       card_detect_a,
    input  wire                       card_detect_b,
    input  wire                       card_ready,
    input  wire                       battery_warn,
    input  wire                       card_status_pin,
    input  wire                       card_is_io,
    // Interrupt outputs
    output reg  [`NUM_LEGACY-1:0]     legacy_irq,
    output reg                        system_mgmt_interrupt,
    output reg                        pci_irq,
    output reg                        irq
);

    // ======================================================================
    // Functions
    // ======================================================================
    function hit;
        input [`ADDR_W-1:0] addr;
        input [`ADDR_W-1:0] target;
        begin
            hit = (addr == target);
        end
    endfunction

    function rose;
        input now_level;
        input last_level;
        begin
            rose = now_level && !last_level;
        end
    endfunction

    // ======================================================================
    // Register state
    // ======================================================================
    reg  [7:0]                 status_change_irq_config_reg;

    reg                        pci_status_route_enable_reg;
    reg                        clear_on_write_reg;
    reg                        diag_pci_route_reg;
    reg  [`NUM_SOURCES-1:0]    irq_mask_reg;

    reg  [`NUM_SOURCES-1:0]    status_reg;
    reg  [`NUM_SOURCES-1:0]    status_next;

    // Previous card levels for edge detection
    reg                        detect_a_reg;
    reg                        detect_b_reg;
    reg                        ready_reg;
    reg                        warn_reg;
    reg                        dead_reg;
    reg                        primed_reg;

    // ======================================================================
    // Field views
    // ======================================================================
    wire [3:0] status_irq_route_select;

    wire       detect_change_irq_enable;
    wire       ready_rise_irq_enable;
    wire       battery_warn_irq_enable;
    wire       battery_dead_irq_enable;

    wire [`NUM_SOURCES-1:0] source_enable;

    assign status_irq_route_select  =
        status_change_irq_config_reg[`CFG_ROUTE_HI:`CFG_ROUTE_LO];

    assign detect_change_irq_enable = status_change_irq_config_reg[`CFG_DETECT_EN];
    assign ready_rise_irq_enable    = status_change_irq_config_reg[`CFG_READY_EN];
    assign battery_warn_irq_enable  = status_change_irq_config_reg[`CFG_BATT_WARN_EN];
    assign battery_dead_irq_enable  = status_change_irq_config_reg[`CFG_BATT_DEAD_EN];

    assign source_enable = {detect_change_irq_enable, ready_rise_irq_enable,
                            battery_warn_irq_enable, battery_dead_irq_enable};

    // ======================================================================
    // Bus handshake
    // ======================================================================
    wire request;
    wire accept;
    wire wr_lane0;

    assign request  = read || write;

    // Request is acted on only at the edge where waitrequest is seen low
    assign accept   = request && !waitrequest;
    assign wr_lane0 = write && accept && byteenable[0];

    // One fixed wait state lets readdata come from a flop

    always @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            waitrequest <= 1'b1;
        end else if (request && waitrequest) begin
            waitrequest <= 1'b0;
        end else begin
            waitrequest <= 1'b1;
        end
    end

    // ======================================================================
    // Read data
    // ======================================================================
    reg [31:0] read_value;

    always @* begin
        read_value = 32'h0000_0000;
        if (hit(address, `CONFIG_ADDR)) begin
            read_value[7:0] = status_change_irq_config_reg;
        end else if (hit(address, `STATUS_ADDR)) begin
            read_value[`NUM_SOURCES-1:0] = status_reg;
        end else if (hit(address, `CTRL_ADDR)) begin
            read_value[`CTRL_PCI_ROUTE] = pci_status_route_enable_reg;
        end else if (hit(address, `GLOBAL_ADDR)) begin
            read_value[`GLOBAL_CLEAR_MODE] = clear_on_write_reg;
        end else if (hit(address, `DIAG_ADDR)) begin
            read_value[`DIAG_PCI_CSC] = diag_pci_route_reg;
        end else if (hit(address, `MASK_ADDR)) begin
            read_value[`NUM_SOURCES-1:0] = irq_mask_reg;
        end
    end

    // Captured one edge before the accept edge; stable while master samples
    always @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            readdata <= 32'h0000_0000;
        end else if (read && waitrequest) begin
            readdata <= read_value;
        end
    end

    // ======================================================================
    // Writable registers
    // ======================================================================
    // Only byte lane 0 carries register bits
    always @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            status_change_irq_config_reg <= `CONFIG_RESET;
            pci_status_route_enable_reg  <= 1'b0;
            clear_on_write_reg           <= 1'b0;
            diag_pci_route_reg           <= 1'b0;
            irq_mask_reg                 <= `MASK_RESET;
        end else if (wr_lane0) begin
            if (hit(address, `CONFIG_ADDR)) begin
                status_change_irq_config_reg <= writedata[7:0];
            end
            if (hit(address, `CTRL_ADDR)) begin
                pci_status_route_enable_reg <= writedata[`CTRL_PCI_ROUTE];
            end
            if (hit(address, `GLOBAL_ADDR)) begin
                clear_on_write_reg <= writedata[`GLOBAL_CLEAR_MODE];
            end
            if (hit(address, `DIAG_ADDR)) begin
                diag_pci_route_reg <= writedata[`DIAG_PCI_CSC];
            end
            if (hit(address, `MASK_ADDR)) begin
                irq_mask_reg <= writedata[`NUM_SOURCES-1:0];
            end
        end
    end

    // ======================================================================
    // Card event detection
    // ======================================================================
    // Previous levels are unknown until the first clocked sample, so
    // edges are ignored for one cycle after reset release.
    always @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            detect_a_reg <= 1'b0;
            detect_b_reg <= 1'b0;
            ready_reg    <= 1'b0;
            warn_reg     <= 1'b0;
            dead_reg     <= 1'b0;
            primed_reg   <= 1'b0;
        end else begin
            detect_a_reg <= card_detect_a;
            detect_b_reg <= card_detect_b;
            ready_reg    <= card_ready;
            warn_reg     <= battery_warn;
            dead_reg     <= card_status_pin;
            primed_reg   <= 1'b1;
        end
    end

    wire [`NUM_SOURCES-1:0] event_raw;
    wire [`NUM_SOURCES-1:0] event_set;

    assign event_raw[`STS_DETECT]    = (card_detect_a ^ detect_a_reg)
                                       || (card_detect_b ^ detect_b_reg);

    // Ready and battery warning have no meaning on an I/O card
    assign event_raw[`STS_READY]     = rose(card_ready, ready_reg) && !card_is_io;
    assign event_raw[`STS_BATT_WARN] = rose(battery_warn, warn_reg) && !card_is_io;

    assign event_raw[`STS_BATT_DEAD] = rose(card_status_pin, dead_reg);

    genvar s;
    generate
        for (s = 0; s < `NUM_SOURCES; s = s + 1) begin : g_src
            assign event_set[s] = primed_reg && event_raw[s]
                                  && source_enable[s];
        end
    endgenerate

    // ======================================================================
    // Status flags
    // ======================================================================
    wire                    status_read_clear;
    wire                    status_write_clear;
    wire [`NUM_SOURCES-1:0] clear_bits;

    assign status_read_clear  = read && accept && hit(address, `STATUS_ADDR)
                                && !clear_on_write_reg;

    assign status_write_clear = wr_lane0 && hit(address, `STATUS_ADDR)
                                && clear_on_write_reg;

    // Clear only what the read returned; a flag set at capture survives
    assign clear_bits = status_read_clear ? readdata[`NUM_SOURCES-1:0] :
                        status_write_clear ? writedata[`NUM_SOURCES-1:0] :
                        {`NUM_SOURCES{1'b0}};

    always @* begin
        // Set wins over a clear in the same cycle; disabling drops the flag
        status_next = ((status_reg & ~clear_bits) | event_set)
                      & source_enable;
    end

    always @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            status_reg <= `STATUS_RESET;
        end else begin
            status_reg <= status_next;
        end
    end

    // ======================================================================
    // Routing and interrupt outputs
    // ======================================================================
    wire                    route_request;
    wire [`NUM_LEGACY-1:0]  legacy_route;
    wire                    mgmt_route;
    wire                    pci_route;

    // Routing follows every set flag; the mask gates only irq
    assign route_request = |status_reg;

    irq_route_decode u_route (
        .route_select     (status_irq_route_select),
        .diag_pci_route   (diag_pci_route_reg),
        .pci_route_enable (pci_status_route_enable_reg),
        .request          (route_request),
        .legacy_irq       (legacy_route),
        .sys_mgmt_irq     (mgmt_route),
        .pci_irq          (pci_route)
    );

    // Outputs follow the flags one edge later
    always @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            legacy_irq            <= {`NUM_LEGACY{1'b0}};
            system_mgmt_interrupt <= 1'b0;
            pci_irq               <= 1'b0;
            irq                   <= 1'b0;
        end else begin
            legacy_irq            <= legacy_route;
            system_mgmt_interrupt <= mgmt_route;
            pci_irq               <= pci_route;
            irq                   <= |(status_reg & irq_mask_reg);
        end
    end

endmodule

// ### rtl/csc_defs.vh
// Purpose: Offsets, field positions, reset values and codes for the
//          status-change interrupt block.
// Assumes: 32-bit Avalon-MM data, byte address equals four times the index.
// Notes:   Definitions only.
`ifndef CSC_DEFS_VH
`define CSC_DEFS_VH

// ==========================================================================
// Register indices and byte addresses
// ==========================================================================
`define CTRL_INDEX          12'h0803
`define STATUS_INDEX        12'h0804
`define CONFIG_INDEX        12'h0805
`define GLOBAL_INDEX        12'h081E
`define DIAG_INDEX          12'h0840
`define MASK_INDEX          12'h0841
`define ADDR_W              14
`define CTRL_ADDR           14'h200C
`define STATUS_ADDR         14'h2010
`define CONFIG_ADDR         14'h2014
`define GLOBAL_ADDR         14'h2078
`define DIAG_ADDR           14'h2100
`define MASK_ADDR           14'h2104

// ==========================================================================
// Field positions
// ==========================================================================
`define CFG_ROUTE_HI        7
`define CFG_ROUTE_LO        4
`define CFG_DETECT_EN       3
`define CFG_READY_EN        2
`define CFG_BATT_WARN_EN    1
`define CFG_BATT_DEAD_EN    0
`define STS_DETECT          3
`define STS_READY           2
`define STS_BATT_WARN       1
`define STS_BATT_DEAD       0
`define CTRL_PCI_ROUTE      4
`define GLOBAL_CLEAR_MODE   2
`define DIAG_PCI_CSC        5

// ==========================================================================
// Reset values and codes
// ==========================================================================
`define CONFIG_RESET        8'h00
`define STATUS_RESET        4'h0
`define MASK_RESET          4'h0
`define ROUTE_NONE          4'h0
`define ROUTE_SYS_MGMT      4'h2
`define NUM_LEGACY          16
`define NUM_SOURCES         4

`endif

// ### rtl/irq_route_decode.v
// Purpose: Steers the combined status-change request to a legacy line,
//          the system management interrupt, or the PCI interrupt.
// Assumes: Purely combinational; the caller registers the results.
// Notes:   Legacy line 0 is never driven; code 0010 goes to management.
`timescale 1ns/100ps
`include "csc_defs.vh"

module irq_route_decode (
    input  wire [3:0]                 route_select,
    input  wire                       diag_pci_route,
    input  wire                       pci_route_enable,
    input  wire                       request,
    output wire [`NUM_LEGACY-1:0]     legacy_irq,
    output wire                       sys_mgmt_irq,
    output wire                       pci_irq
);

    wire route_is_none;
    wire route_is_mgmt;

    assign route_is_none = (route_select == `ROUTE_NONE);
    assign route_is_mgmt = (route_select == `ROUTE_SYS_MGMT);

    // ======================================================================
    // Legacy lines
    // ======================================================================
    genvar i;
    generate
        for (i = 0; i < `NUM_LEGACY; i = i + 1) begin : g_legacy
            if (i == 0) begin : g_zero
                assign legacy_irq[i] = 1'b0;
            end else begin : g_line
                assign legacy_irq[i] = request && (route_select == i)
                                       && !route_is_mgmt;
            end
        end
    endgenerate

    // ======================================================================
    // Management and PCI
    // ======================================================================
    assign sys_mgmt_irq = request && route_is_mgmt;

    // Diagnostic bit overrides the routing bit
    assign pci_irq = request && route_is_none
                     && (diag_pci_route || pci_route_enable);

endmodule

// ### test/status_change_irq_config_asserts.sv
// Purpose: Port-level checks of routing, source enables and bus timing.
// Assumes: Register shadows follow accepted bus writes.
// Notes:   Bound from the testbench top file.
`timescale 1ns/100ps
`include "csc_defs.vh"
module status_change_irq_config_asserts (
    input logic                   core_clk,
    input logic                   resetn,
    input logic [`ADDR_W-1:0]     address,
    input logic                   read,
    input logic                   write,
    input logic [31:0]            writedata,
    input logic [3:0]             byteenable,
    input logic                   waitrequest,
    input logic                   card_detect_a,
    input logic                   card_detect_b,
    input logic                   card_ready,
    input logic                   battery_warn,
    input logic                   card_status_pin,
    input logic                   card_is_io,
    input logic [`NUM_LEGACY-1:0] legacy_irq,
    input logic                   system_mgmt_interrupt,
    input logic                   pci_irq,
    input logic                   irq
);
    // ========================================
    // Shadows
    // ========================================
    logic [7:0] cfg_reg;
    logic [3:0] mask_reg;
    logic       ctrl_route_reg;
    logic       diag_route_reg;
    wire        wr_acc = write && !waitrequest && byteenable[0];
    wire  [3:0] route  = cfg_reg[7:4];
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            cfg_reg        <= 8'h00;
            mask_reg       <= 4'h0;
            ctrl_route_reg <= 1'b0;
            diag_route_reg <= 1'b0;
        end else if (wr_acc) begin
            if (address == `CONFIG_ADDR) cfg_reg <= writedata[7:0];
            if (address == `MASK_ADDR) mask_reg <= writedata[3:0];
            if (address == `CTRL_ADDR) ctrl_route_reg <= writedata[4];
            if (address == `DIAG_ADDR) diag_route_reg <= writedata[5];
        end
    end
    // ========================================
    // Properties
    // ========================================
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!resetn);
    sequence s_detect; (!$stable(card_detect_a) || !$stable(card_detect_b)) && cfg_reg[3]
        && mask_reg[3]; endsequence
    sequence s_ready; $rose(card_ready) && !card_is_io && cfg_reg[2] && mask_reg[2]; endsequence
    sequence s_warn; $rose(battery_warn) && !card_is_io && cfg_reg[1] && mask_reg[1]; endsequence
    sequence s_dead; $rose(card_status_pin) && cfg_reg[0] && mask_reg[0]; endsequence
    sequence s_all_off; cfg_reg[3:0] == 4'h0 [*3]; endsequence
    property p_legacy_code; legacy_irq != 16'h0000 |-> legacy_irq == (16'h0001 << $past(route))
        && $past(route) != `ROUTE_SYS_MGMT && $past(route) != 4'h0; endproperty
    property p_sys_mgmt; system_mgmt_interrupt |-> $past(route) == `ROUTE_SYS_MGMT; endproperty
    property p_pci_on; irq && $past(route) == 4'h0 && $past(diag_route_reg) |-> pci_irq; endproperty
    property p_pci_cause; pci_irq |-> $past(route) == 4'h0
        && ($past(diag_route_reg) || $past(ctrl_route_reg)); endproperty
    property p_route_none; $past(route) == 4'h0 |-> legacy_irq == 16'h0000
        && !system_mgmt_interrupt; endproperty
    property p_detect_irq; s_detect |-> ##[1:3] irq; endproperty
    property p_ready_irq; s_ready |-> ##[1:3] irq; endproperty
    property p_warn_irq; s_warn |-> ##[1:3] irq; endproperty
    property p_dead_irq; s_dead |-> ##[1:3] irq; endproperty
    property p_disabled_quiet; s_all_off |=> !irq && !pci_irq && !system_mgmt_interrupt
        && legacy_irq == 16'h0000; endproperty
    property p_routed_level; irq && $past(route) != 4'h0 |-> legacy_irq != 16'h0000
        || system_mgmt_interrupt; endproperty
    property p_wait_one; (read || write) && waitrequest |=> !waitrequest ##1 waitrequest;
    endproperty
    a_legacy_code: assert property (p_legacy_code)
        else $error("legacy line does not match route code");
    a_sys_mgmt: assert property (p_sys_mgmt)
        else $error("management interrupt without its route code");
    a_pci_on: assert property (p_pci_on)
        else $error("diagnostic route did not reach pci interrupt");
    a_pci_cause: assert property (p_pci_cause)
        else $error("pci interrupt without an enabled pci route");
    a_route_none: assert property (p_route_none)
        else $error("legacy or management line driven with route zero");
    a_detect_irq: assert property (p_detect_irq)
        else $error("detect change raised no interrupt");
    a_ready_irq: assert property (p_ready_irq)
        else $error("ready rise raised no interrupt");
    a_warn_irq: assert property (p_warn_irq)
        else $error("battery warning raised no interrupt");
    a_dead_irq: assert property (p_dead_irq)
        else $error("status pin raised no interrupt");
    a_disabled_quiet: assert property (p_disabled_quiet)
        else $error("interrupt output with all sources disabled");
    a_routed_level: assert property (p_routed_level)
        else $error("pending flag not shown on routed line");
    a_wait_one: assert property (p_wait_one)
        else $error("waitrequest not low for exactly one cycle");
endmodule

// ### test/card_model.sv
// Purpose: Card in the socket: detect, ready, battery and status lines.
// Assumes: Memory card at start; lines change just after a rising edge.
// Notes:   Rising events always start from a low level.
`timescale 1ns/100ps
module card_model (
    input  logic core_clk,
    output logic card_detect_a,
    output logic card_detect_b,
    output logic card_ready,
    output logic battery_warn,
    output logic card_status_pin,
    output logic card_is_io
);
    initial begin
        {card_detect_a, card_detect_b, card_ready} = 3'b000;
        {battery_warn, card_status_pin, card_is_io} = 3'b000;
    end
    // 3 and 4 toggle a detect line, 5 the card type, 0..2 give a rising edge
    task automatic fire(input int src);
        @(posedge core_clk);
        case (src)
            5: card_is_io <= ~card_is_io;
            4: card_detect_b <= ~card_detect_b;
            3: card_detect_a <= ~card_detect_a;
            2: card_ready <= 1'b0;
            1: battery_warn <= 1'b0;
            default: card_status_pin <= 1'b0;
        endcase
        @(posedge core_clk);
        if (src == 2) card_ready <= 1'b1;
        if (src == 1) battery_warn <= 1'b1;
        if (src == 0) card_status_pin <= 1'b1;
    endtask
endmodule

// ### test/status_change_irq_config_tb.sv
// Purpose: Register, source enable and routing tests of the interrupt block.
// Assumes: Two-cycle bus accesses; mask open while routing is tested.
// Notes:   Status reads clear flags unless write-one mode is chosen.
`timescale 1ns/100ps
`include "csc_defs.vh"
`define CHK(got, exp, msg) begin checks++; if ((got) !== (exp)) begin error_cnt++; \
    $display("CHECK FAILED t=%0t %s got %h exp %h", $time, msg, got, exp); end end
module status_change_irq_config_tb;
    logic                   core_clk;
    logic                   resetn;
    logic [`ADDR_W-1:0]     address;
    logic                   read;
    logic                   write;
    logic [31:0]            writedata;
    logic [3:0]             byteenable;
    logic [31:0]            readdata;
    logic                   waitrequest;
    logic [`NUM_LEGACY-1:0] legacy_irq;
    logic                   system_mgmt_interrupt;
    logic                   pci_irq;
    logic                   irq;
    logic                   cd_a, cd_b, rdy, warn, stpin, is_io;
    logic [3:0]             exp_sts;
    logic [15:0]            exp_leg;
    int                     error_cnt, checks, b;
    initial begin
        core_clk = 1'b0;
        forever #50 core_clk = ~core_clk;
    end
    status_change_irq_config u_dut (.core_clk(core_clk), .resetn(resetn), .address(address),
        .read(read), .write(write), .writedata(writedata), .byteenable(byteenable),
        .readdata(readdata), .waitrequest(waitrequest), .card_detect_a(cd_a),
        .card_detect_b(cd_b), .card_ready(rdy), .battery_warn(warn),
        .card_status_pin(stpin), .card_is_io(is_io), .legacy_irq(legacy_irq),
        .system_mgmt_interrupt(system_mgmt_interrupt), .pci_irq(pci_irq), .irq(irq));
    card_model u_card (.core_clk(core_clk), .card_detect_a(cd_a), .card_detect_b(cd_b),
        .card_ready(rdy), .battery_warn(warn), .card_status_pin(stpin), .card_is_io(is_io));
    // ========================================
    // Bus tasks
    // ========================================
    task automatic bus_wr(input logic [13:0] a, input logic [7:0] d);
        @(posedge core_clk);
        address <= a;
        writedata <= {24'h00_0000, d};
        write <= 1'b1;
        do @(posedge core_clk); while (waitrequest !== 1'b0);
        write <= 1'b0;
    endtask
    task automatic rd_chk(input logic [13:0] a, input logic [7:0] e, input string m);
        @(posedge core_clk);
        address <= a;
        read <= 1'b1;
        do @(posedge core_clk); while (waitrequest !== 1'b0);
        `CHK(readdata, {24'h00_0000, e}, m)
        read <= 1'b0;
    endtask
    task automatic settle();
        repeat (4) @(posedge core_clk);
    endtask
    task automatic stop_test();
        $display("Counts: checks=%0d errors=%0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    // ========================================
    // Tests
    // ========================================
    initial begin
        {resetn, read, write, address, writedata} = '0;
        byteenable = 4'hF;
        error_cnt = 0;
        checks = 0;
        repeat (20) @(posedge core_clk);
        resetn <= 1'b1;
        repeat (2) @(posedge core_clk);
        rd_chk(`CONFIG_ADDR, 8'h00, "config reset");
        bus_wr(`CONFIG_ADDR, 8'hA5);
        rd_chk(`CONFIG_ADDR, 8'hA5, "config rw");
        rd_chk(14'h3FFC, 8'h00, "unmapped");
        $display("Test registers done");
        bus_wr(`MASK_ADDR, 8'h0F);
        for (int s = 0; s < 5; s++) for (int en = 0; en < 2; en++) begin
            b = (s == 4) ? 3 : s;
            exp_sts = en ? (4'h1 << b) : 4'h0;
            bus_wr(`CONFIG_ADDR, {4'h5, exp_sts});
            u_card.fire(s);
            settle();
            `CHK({legacy_irq, irq}, {(en ? 16'h0020 : 16'h0000), en[0]}, "event")
            rd_chk(`STATUS_ADDR, {4'h0, exp_sts}, "flag");
            settle();
            `CHK({legacy_irq, irq}, 17'h0_0000, "after clear")
            rd_chk(`STATUS_ADDR, 8'h00, "read clear");
        end
        $display("Test sources done");
        bus_wr(`CONFIG_ADDR, 8'h08);
        u_card.fire(3);
        for (int c = 0; c < 16; c++) begin
            bus_wr(`CONFIG_ADDR, {c[3:0], 4'h8});
            settle();
            exp_leg = (c == 0 || c == 2) ? 16'h0000 : 16'h0001 << c;
            `CHK({legacy_irq, system_mgmt_interrupt, pci_irq}, {exp_leg, c == 2, 1'b0}, "route")
        end
        bus_wr(`CONFIG_ADDR, 8'h08);
        bus_wr(`CTRL_ADDR, 8'h10);
        settle();
        `CHK(pci_irq, 1'b1, "ctrl pci route")
        bus_wr(`CTRL_ADDR, 8'h00);
        bus_wr(`DIAG_ADDR, 8'h20);
        settle();
        `CHK(pci_irq, 1'b1, "diag pci route")
        bus_wr(`DIAG_ADDR, 8'h00);
        bus_wr(`MASK_ADDR, 8'h00);
        settle();
        `CHK({pci_irq, irq}, 2'b00, "masked")
        bus_wr(`MASK_ADDR, 8'h0F);
        bus_wr(`CONFIG_ADDR, 8'h00);
        settle();
        rd_chk(`STATUS_ADDR, 8'h00, "disable drops flag");
        u_card.fire(5);
        bus_wr(`CONFIG_ADDR, 8'h06);
        u_card.fire(2);
        u_card.fire(1);
        settle();
        rd_chk(`STATUS_ADDR, 8'h00, "io card");
        u_card.fire(5);
        $display("Test routing done");
        bus_wr(`GLOBAL_ADDR, 8'h04);
        bus_wr(`CONFIG_ADDR, 8'h18);
        u_card.fire(4);
        settle();
        rd_chk(`STATUS_ADDR, 8'h08, "w1c set");
        rd_chk(`STATUS_ADDR, 8'h08, "read keeps");
        `CHK(legacy_irq, 16'h0002, "held")
        bus_wr(`STATUS_ADDR, 8'h08);
        settle();
        rd_chk(`STATUS_ADDR, 8'h00, "w1c clear");
        `CHK({legacy_irq, irq}, 17'h0_0000, "released")
        $display("Test write-one clear done");
        stop_test();
    end
    initial begin
        repeat (20000) @(posedge core_clk);
        error_cnt++;
        $display("CHECK FAILED t=%0t watchdog expired", $time);
        stop_test();
    end
endmodule
bind status_change_irq_config status_change_irq_config_asserts u_chk (.*);
